// ---- src/ocs_core.sv ----
// Option loader, stack pointer, data memory access and oscillator enables.
module ocs_core import ocs_pkg::*; #(
    parameter int MEM_DEPTH = OCS_MEM_DEPTH,
    parameter int PROG_WORDS = 2048
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Nonvolatile option source.
    input wire logic [13:0] nv_option_word,
    input wire logic [7:0] nv_hrc_trim,
    // Programming tool read-back check.
    input wire logic [10:0] prog_read_addr,
    output logic prog_read_allow,
    // Core stack port.
    input wire logic stack_push,
    input wire logic stack_pop,
    output logic [7:0] stack_addr,
    // Comparator and pins.
    input wire logic comp_out,
    input wire logic port_a_pin0,
    input wire logic port_a_pin5,
    input wire logic [7:0] pwm_raw,
    output logic [7:0] pwm_out,
    output logic comp_irq_pulse,
    output logic irq0_source,
    // Decoded options.
    output logic [2:0] low_voltage_reset_sel,
    output logic pin34_strong_drive,
    output logic timer_a_clk_32m,
    output logic timer_b_clk_32m,
    output logic timer_a_hrc_sel,
    output logic timer_b_hrc_sel,
    output logic [2:0] timer_a_pwm_bits,
    output logic [2:0] timer_b_pwm_bits,
    output logic touch_pad_pa7,
    output logic touch_pad_pb7,
    output logic clock_dither_en,
    // Oscillators.
    output logic crystal_osc_en,
    output logic high_rc_osc_en,
    output logic low_rc_osc_en,
    output logic [7:0] high_rc_trim,
    output logic [2:0] sys_clk_src
);
    // Refuse geometries that the pointer width and the protection split cannot serve.
    if (MEM_DEPTH != 128 || PROG_WORDS % 8 != 0) begin : g_bad_geometry
        $error("ocs_core: unsupported memory geometry");
    end

    logic [13:0] opt_r;
    logic [7:0] trim_r;
    logic [2:0] load_cnt_r;
    logic loaded_r;
    logic [7:0] sp_r;
    logic [7:0] clkmode_r;
    logic [7:0] xosc_r;
    logic [7:0] mem_ptr_r;
    logic [7:0] tmr_a_r;
    logic [7:0] tmr_b_r;
    logic [7:0] mem [MEM_DEPTH];
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic comp_d_r;
    logic comp_irq_r;
    logic [31:0] rdata_r;
    logic ph_valid_r;
    logic ph_write_r;
    logic [11:0] ph_addr_r;

    // Address phase capture.
    wire addr_take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 12'h000;
        end else begin
            ph_valid_r <= addr_take;
            ph_write_r <= hwrite;
            ph_addr_r <= haddr;
        end
    end

    // Write decode in the data phase.
    wire wr = ph_valid_r && ph_write_r;
    wire wr_sp = wr && ph_addr_r == OCS_ADDR_SP;
    wire wr_clk = wr && ph_addr_r == OCS_ADDR_CLKMODE;
    wire wr_xosc = wr && ph_addr_r == OCS_ADDR_XOSC;
    wire wr_ptr = wr && ph_addr_r == OCS_ADDR_MEM_PTR;
    wire wr_data = wr && ph_addr_r == OCS_ADDR_MEM_DATA;
    wire wr_bit = wr && ph_addr_r == OCS_ADDR_MEM_BIT;
    wire wr_ta = wr && ph_addr_r == OCS_ADDR_TMR_A;
    wire wr_tb = wr && ph_addr_r == OCS_ADDR_TMR_B;
    wire [6:0] ptr_idx = mem_ptr_r[6:0];
    wire bit_ok = mem_ptr_r <= OCS_BIT_LIMIT;
    wire [2:0] bit_sel = hwdata[2:0];

    // Data memory write port: indirect byte or indirect bit write.
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = ptr_idx;
        mem_wdata = mem[ptr_idx];
        if (wr_data) begin
            mem_we = 1'b1;
            mem_wdata = hwdata[7:0];
        end else if (wr_bit && bit_ok) begin
            mem_we = 1'b1;
            mem_wdata[bit_sel] = hwdata[8];
        end
    end

    always_ff @(posedge hclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Code options are captured a few cycles after reset release and then frozen.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_r <= OCS_OPT_DEFAULT;
            trim_r <= 8'h80;
            load_cnt_r <= 3'h0;
            loaded_r <= 1'b0;
        end else if (!loaded_r) begin
            load_cnt_r <= load_cnt_r + 3'h1;
            if (load_cnt_r == 3'(OCS_LOAD_CYCLES - 1)) begin
                opt_r <= nv_option_word;
                trim_r <= nv_hrc_trim;
                loaded_r <= 1'b1;
            end
        end
    end

    // Stack pointer: software write wins over push and pop in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_r <= OCS_SP_RST;
        end else if (wr_sp) begin
            sp_r <= hwdata[7:0];
        end else if (stack_push) begin
            sp_r <= sp_r + 8'h02;
        end else if (stack_pop) begin
            sp_r <= sp_r - 8'h02;
        end
    end
    assign stack_addr = sp_r;

    // Software registers for clocks, pointer and timers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clkmode_r <= OCS_CLKMODE_RST;
            xosc_r <= OCS_XOSC_RST;
            mem_ptr_r <= 8'h00;
            tmr_a_r <= 8'h00;
            tmr_b_r <= 8'h00;
        end else begin
            if (wr_clk) clkmode_r <= hwdata[7:0];
            if (wr_xosc) xosc_r <= {hwdata[7:5], 5'h00};
            if (wr_ptr) mem_ptr_r <= {1'b0, hwdata[6:0]};
            if (wr_ta) tmr_a_r <= {hwdata[7:4], 3'h0, hwdata[8]};
            if (wr_tb) tmr_b_r <= {hwdata[7:4], 3'h0, hwdata[8]};
        end
    end

    // Oscillator enables and source selection.
    assign crystal_osc_en = xosc_r[OCS_XOSC_EN];
    assign high_rc_osc_en = clkmode_r[OCS_CLK_HRC_EN];
    assign low_rc_osc_en = clkmode_r[OCS_CLK_LRC_EN];
    assign high_rc_trim = trim_r;
    wire [2:0] clk_sel = clkmode_r[7:5];
    wire is_lrc = clkmode_r[3] ? (clk_sel == 3'h2 || clk_sel == 3'h6) : clk_sel[2] & clk_sel[1];
    wire xosc_type0 = clk_sel == 3'h3 || clk_sel == 3'h4 || clk_sel == 3'h5;
    wire is_xosc = clkmode_r[3] ? clk_sel == 3'h5 : xosc_type0;
    assign sys_clk_src = is_lrc ? OCS_SRC_LRC : (is_xosc ? OCS_SRC_XOSC : OCS_SRC_HRC);

    // Decoded code options.
    assign prog_read_allow = !opt_r[OCS_OPT_SECURE] || prog_read_addr[10:8] == 3'h0;
    assign low_voltage_reset_sel = opt_r[OCS_OPT_LVR_LO +: 3];
    assign pin34_strong_drive = opt_r[OCS_OPT_DRIVE];
    assign timer_a_hrc_sel = tmr_a_r[7:4] == OCS_TSRC_HRC;
    assign timer_b_hrc_sel = tmr_b_r[7:4] == OCS_TSRC_HRC;
    assign timer_a_clk_32m = timer_a_hrc_sel && opt_r[OCS_OPT_TSRC];
    assign timer_b_clk_32m = timer_b_hrc_sel && opt_r[OCS_OPT_TSRC];
    wire [2:0] pwm_bits = opt_r[OCS_OPT_TBIT] ? 3'h7 : 3'h6;
    assign timer_a_pwm_bits = tmr_a_r[0] ? pwm_bits : 3'h0;
    assign timer_b_pwm_bits = tmr_b_r[0] ? pwm_bits : 3'h0;
    assign pwm_out = opt_r[OCS_OPT_GATE] ? (pwm_raw & {8{comp_out}}) : pwm_raw;
    assign irq0_source = opt_r[OCS_OPT_IRQ0] ? port_a_pin5 : port_a_pin0;
    wire [1:0] tpad = opt_r[OCS_OPT_TPAD_LO +: 2];
    assign touch_pad_pa7 = tpad == OCS_TPAD_PA7;
    assign touch_pad_pb7 = tpad == OCS_TPAD_PB7;
    assign clock_dither_en = opt_r[OCS_OPT_DITHER];

    // Comparator edge detection per the edge option.
    wire [1:0] edge_sel = opt_r[OCS_OPT_EDGE_LO +: 2];
    wire rise = comp_out && !comp_d_r;
    wire fall = !comp_out && comp_d_r;
    wire edge_hit = (edge_sel == OCS_EDGE_RISE) ? rise :
                    (edge_sel == OCS_EDGE_FALL) ? fall : (rise | fall);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_d_r <= 1'b0;
            comp_irq_r <= 1'b0;
        end else begin
            comp_d_r <= comp_out;
            comp_irq_r <= edge_hit;
        end
    end
    assign comp_irq_pulse = comp_irq_r;

    // Read mux, registered for the data phase.
    logic [31:0] rmux;
    always_comb begin
        unique case (haddr)
            OCS_ADDR_SP: rmux = {24'h0, sp_r};
            OCS_ADDR_CLKMODE: rmux = {24'h0, clkmode_r};
            OCS_ADDR_XOSC: rmux = {24'h0, xosc_r};
            OCS_ADDR_OPT: rmux = {18'h0, opt_r};
            OCS_ADDR_STATUS: rmux = {28'h0, loaded_r, sys_clk_src};
            OCS_ADDR_TRIM: rmux = {24'h0, trim_r};
            OCS_ADDR_MEM_PTR: rmux = {24'h0, mem_ptr_r};
            OCS_ADDR_MEM_DATA: rmux = {24'h0, mem[ptr_idx]};
            OCS_ADDR_TMR_A: rmux = {23'h0, tmr_a_r[0], tmr_a_r[7:4], 4'h0};
            OCS_ADDR_TMR_B: rmux = {23'h0, tmr_b_r[0], tmr_b_r[7:4], 4'h0};
            default: rmux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            rdata_r <= rmux;
        end
    end
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule // ocs_core

// ---- src/ocs_pkg.sv ----
// Package of register map, code option layout and constants for the option/stack block.
//
// Notes on behaviour
// - Any data byte can be a pointer; indirect access reaches all 128 bytes.
// - Bit operations allowed only at byte addresses 0x00 to 0x3F.
// - Stack lives in data memory where the stack pointer says; software sets depth.
// - Stack pointer reads current value; writes redirect later stack operations at once.
// - Read protection enabled by default blocks read-back of seven eighths of program memory.
// - With read protection disabled the whole program memory reads back.
// - Option picks one of eight reset thresholds, 2.5 volts by default.
// - Option picks strong or normal drive for two high-drive pins, normal default.
// - Timer clock field 0010 selects 16 MHz high RC clock by default.
// - Alternate source option makes field 0010 select doubled 32 MHz clock.
// - Scaler bit 7 set gives 6-bit PWM, or 7-bit under the resolution option; the code takes this enable from timer register bit 8.
// - Comparator interrupt on both edges by default, or rising only, or falling only.
// - Comparator gate option lets comparator output gate all PWM outputs.
// - Interrupt bit 0 comes from port A pin 0, or pin 5 by option.
// - Touch reference pad on port A pin 7, port B pin 7, or disabled.
// - Clock dither option, enabled by default, slightly dithers system clock.
// - Three oscillators enabled independently by their own control bits.
// - Software selects any oscillator as system clock via clock mode register.
// - Low RC oscillator has no trim; only high RC trim value is applied.
package ocs_pkg;
    // Register byte addresses on the bus.
    localparam logic [7:0] OCS_SP_IDX = 8'h02;
    localparam logic [11:0] OCS_ADDR_SP = 12'h008;
    localparam logic [11:0] OCS_ADDR_CLKMODE = 12'h00c;
    localparam logic [11:0] OCS_ADDR_XOSC = 12'h028;
    localparam logic [11:0] OCS_ADDR_OPT = 12'h100;
    localparam logic [11:0] OCS_ADDR_STATUS = 12'h104;
    localparam logic [11:0] OCS_ADDR_TRIM = 12'h108;
    localparam logic [11:0] OCS_ADDR_MEM_PTR = 12'h10c;
    localparam logic [11:0] OCS_ADDR_MEM_DATA = 12'h110;
    localparam logic [11:0] OCS_ADDR_MEM_BIT = 12'h114;
    localparam logic [11:0] OCS_ADDR_TMR_A = 12'h118;
    localparam logic [11:0] OCS_ADDR_TMR_B = 12'h11c;
    // Code option word field positions.
    localparam int OCS_OPT_SECURE = 0;
    localparam int OCS_OPT_LVR_LO = 1;
    localparam int OCS_OPT_DRIVE = 4;
    localparam int OCS_OPT_TSRC = 5;
    localparam int OCS_OPT_TBIT = 6;
    localparam int OCS_OPT_EDGE_LO = 7;
    localparam int OCS_OPT_GATE = 9;
    localparam int OCS_OPT_IRQ0 = 10;
    localparam int OCS_OPT_TPAD_LO = 11;
    localparam int OCS_OPT_DITHER = 13;
    localparam int OCS_OPT_W = 14;
    // Option word defaults: secure, 2.5 V, normal, 16 MHz, 6 bit, all edges,
    // gate off, port A pin 0, port A pin 7, dither on.
    localparam logic [13:0] OCS_OPT_DEFAULT = 14'h2009;
    // Reset threshold codes, 4.0 V down to 1.8 V.
    localparam logic [2:0] OCS_LVR_2V5 = 3'h4;
    // Comparator edge codes.
    localparam logic [1:0] OCS_EDGE_BOTH = 2'h0;
    localparam logic [1:0] OCS_EDGE_RISE = 2'h1;
    localparam logic [1:0] OCS_EDGE_FALL = 2'h2;
    // Touch pad codes.
    localparam logic [1:0] OCS_TPAD_PA7 = 2'h0;
    localparam logic [1:0] OCS_TPAD_PB7 = 2'h1;
    // Timer clock source field value for high RC.
    localparam logic [3:0] OCS_TSRC_HRC = 4'h2;
    // Register field positions and reset values.
    localparam int OCS_CLK_HRC_EN = 4;
    localparam int OCS_CLK_LRC_EN = 2;
    localparam int OCS_XOSC_EN = 7;
    localparam logic [7:0] OCS_CLKMODE_RST = 8'hf4;
    localparam logic [7:0] OCS_XOSC_RST = 8'h00;
    localparam logic [7:0] OCS_SP_RST = 8'h00;
    // Data memory and protection geometry.
    localparam int OCS_MEM_DEPTH = 128;
    localparam logic [7:0] OCS_BIT_LIMIT = 8'h3f;
    // Option load takes this many cycles after reset release.
    localparam int OCS_LOAD_CYCLES = 4;
    // Oscillator states of the source selector.
    typedef enum logic [2:0] {
        OCS_SRC_HRC = 3'b001,
        OCS_SRC_XOSC = 3'b010,
        OCS_SRC_LRC = 3'b100
    } ocs_src_type;
endpackage

// ---- test/ocs_core_assertions.sv ----
// Checker of port relations of the option, stack and oscillator block.
module ocs_core_chk import ocs_pkg::*; (
    // Clock, reset and bus.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    // Options, stack and pins.
    input wire logic [13:0] nv_option_word,
    input wire logic [10:0] prog_read_addr,
    input wire logic prog_read_allow,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [7:0] stack_addr,
    input wire logic comp_out,
    input wire logic comp_irq_pulse,
    input wire logic port_a_pin0,
    input wire logic port_a_pin5,
    input wire logic irq0_source,
    input wire logic [7:0] pwm_raw,
    input wire logic [7:0] pwm_out,
    input wire logic [2:0] low_voltage_reset_sel
);
    logic [2:0] cnt_r;
    logic [13:0] opt_r;
    logic sp_dp_r;
    // Load state, stack pointer write decode and its data byte.
    wire loaded = (cnt_r == 3'h4);
    wire sp_ap = hsel && hready && htrans[1] && hwrite && (haddr == OCS_ADDR_SP);
    wire [7:0] wr_lo = hwdata[7:0];
    // Counts load edges, copies the option word and marks stack pointer data phases.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 3'h0;
            opt_r <= '0;
            sp_dp_r <= 1'b0;
        end else begin
            if (!loaded) begin
                cnt_r <= cnt_r + 3'h1;
                opt_r <= nv_option_word;
            end
            sp_dp_r <= sp_ap;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Address phase followed by the data phase of a stack pointer write.
    sequence s_sp_wr;
        sp_ap ##1 1'b1;
    endsequence
    AST_SECURE: assert property (loaded |->
        prog_read_allow == (!opt_r[0] || prog_read_addr[10:8] == 3'h0))
        else $error("read-back permission wrong");
    AST_LVR: assert property (loaded |-> low_voltage_reset_sel == opt_r[3:1])
        else $error("threshold select wrong");
    AST_IRQ0: assert property (loaded |->
        irq0_source == (opt_r[10] ? port_a_pin5 : port_a_pin0))
        else $error("interrupt source wrong");
    AST_GATE: assert property (loaded |->
        pwm_out == (opt_r[9] ? (pwm_raw & {8{comp_out}}) : pwm_raw))
        else $error("pwm gating wrong");
    AST_EDGE: assert property (loaded && (($rose(comp_out) && opt_r[8:7] != OCS_EDGE_FALL) ||
        ($fell(comp_out) && opt_r[8:7] != OCS_EDGE_RISE)) |=> comp_irq_pulse)
        else $error("comparator pulse missing");
    AST_PUSH: assert property (stack_push && !stack_pop && !sp_dp_r |=>
        stack_addr == $past(stack_addr) + 8'h02)
        else $error("push step wrong");
    AST_POP: assert property (stack_pop && !stack_push && !sp_dp_r |=>
        stack_addr == $past(stack_addr) - 8'h02)
        else $error("pop step wrong");
    AST_SPWR: assert property (s_sp_wr |=> stack_addr == $past(wr_lo))
        else $error("stack pointer write not applied");
endmodule // ocs_core_chk

bind ocs_core ocs_core_chk u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .nv_option_word,
    .prog_read_addr, .prog_read_allow, .stack_push, .stack_pop, .stack_addr, .comp_out,
    .comp_irq_pulse, .port_a_pin0, .port_a_pin5, .irq0_source, .pwm_raw, .pwm_out,
    .low_voltage_reset_sel
);

// ---- test/ocs_core_tb.sv ----
// Self-checking bench of the option, stack and oscillator block.
module ocs_core_tb import ocs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench drives, design outputs and counters.
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stack_push = 1'b0;
    logic stack_pop = 1'b0, comp_out = 1'b0, port_a_pin0 = 1'b0, port_a_pin5 = 1'b0;
    logic [11:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [13:0] nv_option_word = '0;
    logic [7:0] nv_hrc_trim = '0, pwm_raw = '0;
    logic [10:0] prog_read_addr = '0;
    logic hreadyout, hresp, prog_read_allow, comp_irq_pulse, irq0_source, pin34_strong_drive;
    logic timer_a_clk_32m, timer_b_clk_32m, timer_a_hrc_sel, timer_b_hrc_sel, touch_pad_pa7;
    logic touch_pad_pb7, clock_dither_en, crystal_osc_en, high_rc_osc_en, low_rc_osc_en;
    logic [31:0] hrdata, q;
    logic [7:0] stack_addr, pwm_out, high_rc_trim, sp, v;
    logic [2:0] low_voltage_reset_sel, timer_a_pwm_bits, timer_b_pwm_bits, sys_clk_src;
    logic [13:0] o;
    logic c1, c2;
    int n_fail = 0, cmp_count = 0, seed = 56;
    wire hready = hreadyout;
    always #4 hclk = ~hclk;
    ocs_core dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .nv_option_word, .nv_hrc_trim, .prog_read_addr, .prog_read_allow,
        .stack_push, .stack_pop, .stack_addr, .comp_out, .port_a_pin0, .port_a_pin5, .pwm_raw,
        .pwm_out, .comp_irq_pulse, .irq0_source, .low_voltage_reset_sel, .pin34_strong_drive,
        .timer_a_clk_32m, .timer_b_clk_32m, .timer_a_hrc_sel, .timer_b_hrc_sel,
        .timer_a_pwm_bits, .timer_b_pwm_bits, .touch_pad_pa7, .touch_pad_pb7, .clock_dither_en,
        .crystal_osc_en, .high_rc_osc_en, .low_rc_osc_en, .high_rc_trim, .sys_clk_src
    );
    // Compares a seen value with the expected one.
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Expected comparator pulse for the edge option and two successive pin levels.
    function automatic logic edge_exp(input logic [1:0] s, input logic a, input logic b);
        edge_exp = (s == OCS_EDGE_RISE) ? (!a && b) : (s == OCS_EDGE_FALL) ? (a && !b) : (a != b);
    endfunction
    // One single bus transfer; read data lands in q.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        chk("resp", {31'h0, hresp}, 32'h0);
    endtask
    // Prints the counts and the verdict, then stops.
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        finish_test;
    end
    // Main sequence: one pass per option word.
    initial begin
        for (int it = 0; it < 6; it++) begin
            o = (it == 0) ? 14'h2009 : (it == 1) ? 14'h1eff :
                (it == 2) ? 14'h1f7e : 14'($random(seed));
            if (o[8:7] == 2'h3) o[8] = 1'b0;
            @(posedge hclk);
            hresetn <= 1'b0;
            comp_out <= 1'b0;
            nv_option_word <= o;
            nv_hrc_trim <= 8'($random(seed));
            repeat (6) @(posedge hclk);
            hresetn <= 1'b1;
            repeat (6) @(negedge hclk);
            chk("lvr", low_voltage_reset_sel, o[3:1]);
            chk("drive", pin34_strong_drive, o[4]);
            chk("pad", {touch_pad_pa7, touch_pad_pb7},
                {o[12:11] == 2'h0, o[12:11] == 2'h1});
            chk("dither", clock_dither_en, o[13]);
            chk("trim", high_rc_trim, nv_hrc_trim);
            chk("osc", {crystal_osc_en, high_rc_osc_en, low_rc_osc_en}, 3'b011);
            chk("src", sys_clk_src, OCS_SRC_LRC);
            bus(1'b1, OCS_ADDR_OPT, {18'h0, ~o});
            bus(1'b0, OCS_ADDR_OPT, 32'h0);
            chk("opt", q, {18'h0, o});
            bus(1'b0, 12'h200, 32'h0);
            chk("unmapped", q, 32'h0);
            c1 = 1'b0;
            c2 = 1'b0;
            for (int k = 0; k < 8; k++) begin
                @(posedge hclk);
                prog_read_addr <= {3'(k), 8'($random(seed))};
                {port_a_pin0, port_a_pin5, comp_out} <= 3'($random(seed));
                pwm_raw <= 8'($random(seed));
                @(negedge hclk);
                chk("allow", prog_read_allow, !o[0] || k == 0);
                chk("irq0", irq0_source, o[10] ? port_a_pin5 : port_a_pin0);
                chk("pwm", pwm_out, o[9] ? (pwm_raw & {8{comp_out}}) : pwm_raw);
                chk("edge", comp_irq_pulse, edge_exp(o[8:7], c2, c1));
                c2 = c1;
                c1 = comp_out;
            end
            for (int k = 0; k < 4; k++) begin
                v = 8'($random(seed));
                if (k < 2) v[7:4] = OCS_TSRC_HRC;
                bus(1'b1, OCS_ADDR_TMR_A, {23'h0, v[0], v[7:4], 4'h0});
                bus(1'b1, OCS_ADDR_TMR_B, {23'h0, v[0], v[7:4], 4'h0});
                @(negedge hclk);
                chk("hrc", {timer_a_hrc_sel, timer_b_hrc_sel}, {2{v[7:4] == 4'h2}});
                chk("32m", {timer_a_clk_32m, timer_b_clk_32m}, {2{v[7:4] == 4'h2 && o[5]}});
                chk("bits", {timer_a_pwm_bits, timer_b_pwm_bits},
                    {2{v[0] ? (o[6] ? 3'd7 : 3'd6) : 3'd0}});
            end
            v = 8'($random(seed));
            bus(1'b1, OCS_ADDR_CLKMODE, {24'h0, v});
            bus(1'b1, OCS_ADDR_XOSC, {24'h0, ~v});
            @(negedge hclk);
            chk("osc", {crystal_osc_en, high_rc_osc_en, low_rc_osc_en},
                {~v[7], v[4], v[2]});
            bus(1'b0, OCS_ADDR_SP, 32'h0);
            chk("sp rst", q, {24'h0, OCS_SP_RST});
            sp = 8'($random(seed)) & 8'hfe;
            bus(1'b1, OCS_ADDR_SP, {24'h0, sp});
            for (int k = 0; k < 10; k++) begin
                v = 8'($random(seed));
                @(posedge hclk);
                {stack_push, stack_pop} <= {v[0], ~v[0]};
                sp = v[0] ? sp + 8'h02 : sp - 8'h02;
                @(posedge hclk);
                {stack_push, stack_pop} <= 2'h0;
            end
            @(negedge hclk);
            chk("stack", stack_addr, sp);
            bus(1'b0, OCS_ADDR_SP, 32'h0);
            chk("sp", q, {24'h0, sp});
            v = 8'($random(seed));
            bus(1'b1, OCS_ADDR_MEM_PTR, {25'h0, v[6:1], 1'b0});
            bus(1'b1, OCS_ADDR_MEM_DATA, {24'h0, v});
            bus(1'b1, OCS_ADDR_MEM_PTR, 32'h7f);
            bus(1'b1, OCS_ADDR_MEM_DATA, {24'h0, ~v});
            bus(1'b1, OCS_ADDR_MEM_PTR, {25'h0, v[6:1], 1'b0});
            bus(1'b0, OCS_ADDR_MEM_DATA, 32'h0);
            chk("mem", q, {24'h0, v});
            for (int j = 0; j < 2; j++) begin
                bus(1'b1, OCS_ADDR_MEM_PTR, 32'h3f + j);
                bus(1'b1, OCS_ADDR_MEM_DATA, 32'h0);
                bus(1'b1, OCS_ADDR_MEM_BIT, {23'h0, 1'b1, 5'h0, v[2:0]});
                bus(1'b0, OCS_ADDR_MEM_DATA, 32'h0);
                chk("bit", q, (j == 0) ? (32'h1 << v[2:0]) : 32'h0);
            end
        end
        finish_test;
    end
endmodule // ocs_core_tb
